// ### dmbl_bit_logic.sv
// Bit-level core of the delta modulator: source select, history, outputs.
`timescale 1ns/100ps
module dmbl_bit_logic (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bit_clk_i,
  input  wire logic cmp_ain_gt_fb_i,
  input  wire logic data_in_i,
  input  wire logic mode_encode_i,
  output logic      data_out_o,
  output logic      slope_src_o,
  input  wire logic coinc_n_i,
  output logic      coinc_n_o,
  output logic      coinc_n_oe_o,
  output logic      bit_strobe_o,
  output logic      bit_fifo_data_o,
  output logic      bit_fifo_valid_o,
  input  wire logic bit_fifo_ready_i,
  output logic      bit_fifo_in_ready_o
);
  typedef struct packed {
    logic [1:0]                     clk_sync;
    logic                           clk_prev;
    logic [1:0]                     cmp_sync;
    logic [1:0]                     data_sync;
    logic [1:0]                     mode_sync;
    logic [dmbl_pkg::HIST_W-1:0]    hist;
    logic                           dout;
    logic                           slope;
    logic                           coinc_oe;
    logic                           strobe;
    logic                           push;
    logic                           push_bit;
    logic                           fifo_dout;
    logic                           fifo_vld;
    logic                           fifo_rdy;
  } dmbl_core_s;

  dmbl_core_s state_ff;
  dmbl_core_s nxt_state;
  logic       fall;
  logic       sel_bit;
  logic       fifo_in_ready;
  logic       fifo_data;
  logic       fifo_valid;

  // Pins are synchronised; only the second stage of each chain is read.
  assign fall    = state_ff.clk_prev & ~state_ff.clk_sync[1];
  assign sel_bit = state_ff.mode_sync[1] ? state_ff.cmp_sync[1]
                                         : state_ff.data_sync[1];

  // Next state: shift once per falling edge, outputs follow the new history.
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.clk_sync  = {state_ff.clk_sync[0], bit_clk_i};
    nxt_state.clk_prev  = state_ff.clk_sync[1];
    nxt_state.cmp_sync  = {state_ff.cmp_sync[0], cmp_ain_gt_fb_i};
    nxt_state.data_sync = {state_ff.data_sync[0], data_in_i};
    nxt_state.mode_sync = {state_ff.mode_sync[0], mode_encode_i};
    nxt_state.strobe    = fall;
    nxt_state.push      = fall;
    nxt_state.push_bit  = sel_bit;
    // FIFO head is registered here so every top output except the tied-low coinc_n_o comes from a flip-flop.
    nxt_state.fifo_dout = fifo_data;
    nxt_state.fifo_vld  = fifo_valid;
    nxt_state.fifo_rdy  = fifo_in_ready;
    if (fall) begin
      nxt_state.hist  = {state_ff.hist[dmbl_pkg::HIST_W-2:0], sel_bit};
      // Output is the inverted newest bit, so a loop back toggles it.
      nxt_state.dout  = ~sel_bit;
      nxt_state.slope = sel_bit;
    end
    // Flag tracks whatever the history holds next, newest stage included.
    nxt_state.coinc_oe = (&nxt_state.hist) | ~(|nxt_state.hist);
  end

  // Registered state; the history reset value is arbitrary but defined.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff          <= '0;
      state_ff.clk_sync <= dmbl_pkg::BCLK_SYNC_RST;
      state_ff.clk_prev <= dmbl_pkg::BCLK_PREV_RST;
      state_ff.hist     <= dmbl_pkg::HIST_RST;
      state_ff.coinc_oe <= dmbl_pkg::COINC_OE_RST;
      state_ff.dout     <= dmbl_pkg::DOUT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Copy of every produced bit for a user stream; a full FIFO drops bits.
  dmbl_fifo #(
    .W     (dmbl_pkg::FIFO_W),
    .DEPTH (dmbl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (state_ff.push_bit),
    .in_valid_i  (state_ff.push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (bit_fifo_ready_i)
  );

  // Top outputs are plain copies of state flip-flops, except coinc_n_o, which is tied low.
  assign data_out_o          = state_ff.dout;
  assign slope_src_o         = state_ff.slope;
  assign coinc_n_o           = 1'b0;
  assign coinc_n_oe_o        = state_ff.coinc_oe;
  assign bit_strobe_o        = state_ff.strobe;
  assign bit_fifo_data_o     = state_ff.fifo_dout;
  assign bit_fifo_valid_o    = state_ff.fifo_vld;
  assign bit_fifo_in_ready_o = state_ff.fifo_rdy;

  // The sensed coincidence level is not needed internally.
  logic unused_coinc;
  assign unused_coinc = coinc_n_i;
endmodule : dmbl_bit_logic

// ### dmbl_pkg.sv
// Shared constants for the delta modulator bit logic.
// How it works
// - Keep three newest bits; coincidence pin pulls low when all three match.
// - History shifts once per falling bit-clock edge, taking the selected source.
// - Serial output changes only at a falling bit-clock edge, showing the inverse of the newest bit.
// - Encode: output low if analog input above feedback, high otherwise.
// - Mode high loads the comparator result; mode low loads the data input.
// - Decode: output is the inverse of data input sampled at last fall.
// - Slope direction sources current when newest bit is one, sinks otherwise.
// - One bit per bit-clock period; bit rate equals that clock rate.
// - Output looped to data input in decode toggles every falling edge.
// - Idle encoder loop settles into a one-zero alternation on the output.
package dmbl_pkg;
  localparam int unsigned HIST_W     = 3;
  localparam int unsigned FIFO_W     = 1;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [2:0]  HIST_RST   = 3'h0;
  // The bit-clock sync chain starts at the clock's high level, so release sees no false fall.
  localparam logic [1:0]  BCLK_SYNC_RST = 2'h3;
  localparam logic        BCLK_PREV_RST = 1'b1;
  // Output and flag reset values match the all-zero history above.
  localparam logic        DOUT_RST      = 1'b1;
  localparam logic        COINC_OE_RST  = 1'b1;
endpackage : dmbl_pkg

// ### dmbl_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module dmbl_fifo #(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } dmbl_fifo_s;

  dmbl_fifo_s state_ff;
  dmbl_fifo_s nxt_state;
  logic       push;
  logic       pop;

  // Full and empty come straight from the stored count, so they never lie.
  assign in_ready_o  = (state_ff.count != (AW+1)'(DEPTH));
  assign out_valid_o = (state_ff.count != '0);
  assign out_data_o  = state_ff.mem[state_ff.rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update; simultaneous push and pop keep the count.
  always_comb begin
    nxt_state = state_ff;
    if (push) begin
      nxt_state.mem[state_ff.wr_ptr] = in_data_i;
      nxt_state.wr_ptr = state_ff.wr_ptr + AW'(1);
    end
    if (pop) begin
      nxt_state.rd_ptr = state_ff.rd_ptr + AW'(1);
    end
    case ({push, pop})
      2'b10:   nxt_state.count = state_ff.count + (AW+1)'(1);
      2'b01:   nxt_state.count = state_ff.count - (AW+1)'(1);
      default: nxt_state.count = state_ff.count;
    endcase
  end

  // Storage is not cleared on reset; only the pointers and the count are.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff        <= nxt_state;
      state_ff.wr_ptr <= '0;
      state_ff.rd_ptr <= '0;
      state_ff.count  <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : dmbl_fifo

// ### dmbl_monitor.sv
// Port checker for the delta modulator bit logic.
`timescale 1ns/100ps
module dmbl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_clk_i,
  input wire logic cmp_ain_gt_fb_i,
  input wire logic data_in_i,
  input wire logic mode_encode_i,
  input wire logic data_out_o,
  input wire logic slope_src_o,
  input wire logic coinc_n_oe_o,
  input wire logic bit_strobe_o
);
  logic [2:0] hist_ff;
  logic [2:0] nxt_hist;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of the three newest bits, so the flag is judged without the body.
  assign nxt_hist = bit_strobe_o ? {hist_ff[1:0], slope_src_o} : hist_ff;
  always_ff @(posedge clk_i) hist_ff <= rst_i ? 3'h0 : nxt_hist;
  a_coinc_match: assert property (coinc_n_oe_o == (nxt_hist inside {3'h0, 3'h7}))
    else $error("coincidence wrong");
  a_coinc_hold: assert property (!bit_strobe_o |-> $stable(coinc_n_oe_o))
    else $error("coincidence moved");
  a_fall_strobe: assert property ($fell(bit_clk_i) |-> ##[1:4] bit_strobe_o)
    else $error("no bit after fall");
  a_strobe_cause: assert property (bit_strobe_o |-> !$past(bit_clk_i, 2))
    else $error("bit without fall");
  a_strobe_gap: assert property (bit_strobe_o |=> !bit_strobe_o [*5])
    else $error("bits too close");
  a_out_hold: assert property ($changed(data_out_o) |-> bit_strobe_o)
    else $error("output moved");
  a_out_slope: assert property (data_out_o != slope_src_o)
    else $error("output equals slope");
  a_src_sel: assert property (bit_strobe_o |-> slope_src_o == ($past(mode_encode_i, 3) ?
      $past(cmp_ain_gt_fb_i, 3) : $past(data_in_i, 3)))
    else $error("wrong source");
  c_enc: cover property (bit_strobe_o && mode_encode_i);
  c_dec: cover property (bit_strobe_o && !mode_encode_i);
  c_coinc: cover property ($rose(coinc_n_oe_o));
endmodule : dmbl_monitor
bind dmbl_bit_logic dmbl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .bit_clk_i(bit_clk_i),
  .cmp_ain_gt_fb_i(cmp_ain_gt_fb_i), .data_in_i(data_in_i), .mode_encode_i(mode_encode_i),
  .data_out_o(data_out_o), .slope_src_o(slope_src_o), .coinc_n_oe_o(coinc_n_oe_o),
  .bit_strobe_o(bit_strobe_o));

// ### dmbl_far_end.sv
// Far side model: bit clock, comparator over an integrator, data channel.
`timescale 1ns/100ps
module dmbl_far_end (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              slope_i,
  input  wire logic              loop_i,
  input  wire logic              sel_i,
  input  wire logic              pat_i,
  input  wire logic signed [7:0] tgt_i,
  output logic                   bclk_o,
  output logic                   cmp_o,
  output logic                   data_o
);
  logic        [3:0] cnt_ff;
  logic signed [7:0] integ_ff;
  // The integrator steps at the clock rise, well away from the sampling fall.
  always_ff @(posedge clk_i) begin
    cnt_ff <= rst_i ? 4'h0 : cnt_ff + 4'h1;
    if (rst_i) integ_ff <= 8'sh00;
    else if (cnt_ff == 4'hf) integ_ff <= slope_i ? integ_ff + 8'sh01 : integ_ff - 8'sh01;
  end
  assign bclk_o = ~cnt_ff[3];
  assign cmp_o  = tgt_i > integ_ff;
  assign data_o = sel_i ? loop_i : pat_i;
endmodule : dmbl_far_end

// ### dmbl_bit_logic_tb.sv
// Self-checking bench of the bit logic with random and corner stimulus.
`timescale 1ns/100ps
module dmbl_bit_logic_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, mode = 1'b1, pat = 1'b0, sel = 1'b0, rdy = 1'b0;
  logic signed [7:0] tgt = 8'sh00;
  logic [2:0] h = 3'h0;
  logic [31:0] r = 32'h0000_72f6;
  logic bclk, cmp, din, dout, slope, oe, stb, fd, fv, fir, eb, q0, cn;
  int fails = 0, checked = 0, n, k;
  always #2.5 clk_i = ~clk_i;
  dmbl_far_end far (.clk_i(clk_i), .rst_i(rst_i), .slope_i(slope), .loop_i(dout), .sel_i(sel),
    .pat_i(pat), .tgt_i(tgt), .bclk_o(bclk), .cmp_o(cmp), .data_o(din));
  dmbl_bit_logic uut (.clk_i(clk_i), .rst_i(rst_i), .bit_clk_i(bclk), .cmp_ain_gt_fb_i(cmp),
    .data_in_i(din), .mode_encode_i(mode), .data_out_o(dout), .slope_src_o(slope),
    .coinc_n_i(~oe), .coinc_n_o(cn), .coinc_n_oe_o(oe), .bit_strobe_o(stb), .bit_fifo_data_o(fd),
    .bit_fifo_valid_o(fv), .bit_fifo_ready_i(rdy), .bit_fifo_in_ready_o(fir));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Coincidence is expected when the three newest bits all agree.
  function automatic logic coinc_exp(input logic [2:0] v);
    return v == 3'h0 || v == 3'h7;
  endfunction : coinc_exp
  task automatic chk(input string s, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", s, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // Bounded wait: 1 bit clock high, 0 bit clock low, 2 strobe.
  task automatic wt(input int s);
    for (k = 0; ((s == 2) ? stb : bclk) !== (s != 0) && k < 40; k++) @(posedge clk_i) #1;
    if (k == 40) begin
      fails++;
      final_report();
    end
  endtask : wt
  // Idle encode and loop-back both alternate from reset, so bit n is n[0] there.
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("reset out", 1'b1, dout);
    for (n = 0; n < 100; n++) begin
      wt(1);
      r = lfsr(r);
      mode = n < 16 || (n >= 32 && r[1]);
      sel = n >= 16 && n < 32;
      pat = r[0];
      tgt = n < 32 ? 8'sh00 : {{4{r[5]}}, r[5:2]};
      rdy = n >= 24;
      wt(0);
      eb = n < 32 ? n[0] : (mode ? cmp : pat);
      if (n == 0) q0 = eb;
      h = {h[1:0], eb};
      wt(2);
      chk("data out", ~eb, dout);
      chk("slope", eb, slope);
      chk("coincidence", coinc_exp(h), oe);
      chk("coincidence pull", 1'b0, cn);
      if (n == 23) chk("fifo full", 1'b0, fir);
      if (n == 23) chk("fifo valid", 1'b1, fv);
      if (n == 30) chk("fifo room", 1'b1, fir);
      if (n == 23) chk("fifo head", q0, fd);
      if (n == 30) chk("fifo empty", 1'b0, fv);
    end
    final_report();
  end
endmodule : dmbl_bit_logic_tb
